// ===== sfep_flash_engine.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - 64K block erase sets the whole addressed 64K block to ones.
// - 32K block erase sets the whole addressed 32K block to ones.
// - host sets the write enable latch first; erase/program only act while set.
// - block erase is opcode, three address bytes on lane 0, then select release.
// - any address inside a block selects that whole block.
// - erase select release must fall exactly after the last address byte.
// - select release starts timed cycle; busy held, then cleared with latch.
// - protected target leaves the array unchanged but still clears the latch.
// - chip erase is the opcode alone, then release; whole array goes to ones.
// - any protection anywhere blocks chip erase, latch still cleared.
// - single-lane commands ignore the upper three lanes.
// - page write is opcode, address, at least one data byte; only clears bits.
// - data past the page end wraps to the page start.
// - beyond 256 bytes only the last 256 received are kept.
// - fewer than 256 bytes program only the addressed bytes.
// - page write release must fall on a data byte boundary, else rejected.
// - quad page write also needs the quad lane enable bit.
// - quad page write sends address and data nibble-wide on four lanes.
// - quad page write otherwise behaves like single-lane page write.
module sfep_flash_engine #(
    parameter int unsigned P_BLOCK_ERASE_CYC = sfep_pkg::BLOCK_ERASE_CYC,
    parameter int unsigned P_ARRAY_ERASE_CYC = sfep_pkg::ARRAY_ERASE_CYC,
    parameter int unsigned P_PAGE_WRITE_CYC = sfep_pkg::PAGE_WRITE_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic [3:0] I_SIO,
    input wire logic I_QUAD_LANE_ENABLE,
    input wire logic I_PROTECT_MODE_SELECT,
    input wire logic I_BLOCK_PROTECT_HIT,
    input wire logic I_LOCK_HIT,
    input wire logic I_ANY_PROTECTED,
    output logic O_WRITE_IN_PROGRESS,
    output logic O_WRITE_ENABLE_LATCH,
    output logic [sfep_pkg::ADDR_W-1:0] O_CHECK_ADDR,
    output logic O_ERASE_GO,
    output sfep_pkg::sfep_erase_kind_t O_ERASE_KIND,
    output logic [sfep_pkg::ADDR_W-1:0] O_ERASE_BASE,
    output logic O_PROG_WE,
    output logic [sfep_pkg::ADDR_W-1:0] O_PROG_ADDR,
    output logic [7:0] O_PROG_DATA
);
    import sfep_pkg::*;

    typedef enum logic [3:0] {
        FS_OPC = 4'h1,
        FS_ADDR = 4'h2,
        FS_DATA = 4'h4,
        FS_EXTRA = 4'h8
    } sfep_frame_t;

    typedef enum logic [3:0] {
        EN_IDLE = 4'h1,
        EN_PROG = 4'h2,
        EN_WAIT = 4'h4,
        EN_END = 4'h8
    } sfep_eng_t;

    function automatic logic is_erase(input logic [7:0] op);
        is_erase = (op == OP_BLOCK_ERASE_64K) || (op == OP_HALF_BLOCK_ERASE);
    endfunction

    function automatic logic is_prog(input logic [7:0] op);
        is_prog = (op == OP_PAGE_WRITE) || (op == OP_QUAD_PAGE_WRITE);
    endfunction

    function automatic logic is_chip(input logic [7:0] op);
        is_chip = (op == OP_ARRAY_ERASE_A) || (op == OP_ARRAY_ERASE_B);
    endfunction

    logic cs_s1_r, cs_s2_r, cs_q_r;
    logic sclk_s1_r, sclk_s2_r, sclk_q_r;
    logic [3:0] sio_s1_r, sio_s2_r;
    logic cs_rise, cs_fall, sclk_rise;

    // link clock is only sampled; 400 ns period gives eight samples per bit
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_q_r <= 1'b1;
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_q_r <= 1'b0;
            sio_s1_r <= 4'h0;
            sio_s2_r <= 4'h0;
        end else begin
            cs_s1_r <= I_CS_N;
            cs_s2_r <= cs_s1_r;
            cs_q_r <= cs_s2_r;
            sclk_s1_r <= I_SCLK;
            sclk_s2_r <= sclk_s1_r;
            sclk_q_r <= sclk_s2_r;
            sio_s1_r <= I_SIO;
            sio_s2_r <= sio_s1_r;
        end
    end

    assign cs_rise = cs_s2_r && !cs_q_r;
    assign cs_fall = !cs_s2_r && cs_q_r;
    assign sclk_rise = sclk_s2_r && !sclk_q_r && !cs_s2_r;

    sfep_frame_t fs_r;
    sfep_eng_t eng_r;
    logic [7:0] op_r, sh_r, sh_nxt;
    logic [2:0] bit_cnt_r, bit_nxt;
    logic [1:0] abyte_r;
    logic [ADDR_W-1:0] addr_r;
    logic [PAGE_AW-1:0] idx_r;
    logic got_data_r, over_r, quad_ph, byte_done;
    logic [PAGE_BYTES-1:0] valid_r;
    logic wip_r, wel_r, buf_wr;

    assign quad_ph = (fs_r != FS_OPC) && (op_r == OP_QUAD_PAGE_WRITE);
    assign sh_nxt = quad_ph ? {sh_r[3:0], sio_s2_r} : {sh_r[6:0], sio_s2_r[0]};
    assign bit_nxt = quad_ph ? 3'(bit_cnt_r + 3'h4) : 3'(bit_cnt_r + 3'h1);
    assign byte_done = sclk_rise && (bit_nxt == 3'h0);
    assign buf_wr = byte_done && (fs_r == FS_DATA) && !wip_r;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fs_r <= FS_OPC;
            op_r <= 8'h00;
            sh_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            abyte_r <= 2'h0;
            addr_r <= ADDR_RST;
            idx_r <= 8'h00;
            got_data_r <= 1'b0;
            over_r <= 1'b0;
        end else if (cs_fall) begin
            fs_r <= FS_OPC;
            op_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            abyte_r <= 2'h0;
            got_data_r <= 1'b0;
            over_r <= 1'b0;
        end else if (sclk_rise) begin
            sh_r <= sh_nxt;
            bit_cnt_r <= bit_nxt;
            if (byte_done) begin
                case (fs_r)
                    FS_OPC: begin
                        op_r <= sh_nxt;
                        fs_r <= (is_erase(sh_nxt) || is_prog(sh_nxt)) ? FS_ADDR : FS_EXTRA;
                    end
                    FS_ADDR: begin
                        addr_r <= {addr_r[15:0], sh_nxt};
                        abyte_r <= 2'(abyte_r + 2'h1);
                        if (abyte_r == 2'(ADDR_BYTES - 2'h1)) begin
                            idx_r <= sh_nxt;
                            fs_r <= is_prog(op_r) ? FS_DATA : FS_EXTRA;
                        end
                    end
                    FS_DATA: begin
                        idx_r <= 8'(idx_r + 8'h01);
                        got_data_r <= 1'b1;
                    end
                    FS_EXTRA: begin
                        over_r <= 1'b1;
                    end
                    default: begin
                        fs_r <= FS_OPC;
                    end
                endcase
            end
        end
    end

    // later bytes at the same index overwrite earlier ones, so only the last 256 survive
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            valid_r <= '0;
        end else if (cs_fall && !wip_r) begin
            valid_r <= '0;
        end else if (buf_wr) begin
            valid_r[idx_r] <= 1'b1;
        end
    end

    logic frame_end_ok, opc_only_ok, erase_ok, prog_ok, chip_ok, write_enable_cmd_ok, prot_hit, launch;
    assign frame_end_ok = (bit_cnt_r == 3'h0) && !over_r;
    assign opc_only_ok = frame_end_ok && (fs_r == FS_EXTRA);
    assign write_enable_cmd_ok = opc_only_ok && (op_r == OP_WRITE_ENABLE_CMD);
    assign chip_ok = opc_only_ok && is_chip(op_r);
    assign erase_ok = opc_only_ok && is_erase(op_r) && (abyte_r == ADDR_BYTES);
    assign prog_ok = frame_end_ok && (fs_r == FS_DATA) && got_data_r && is_prog(op_r)
        && ((op_r != OP_QUAD_PAGE_WRITE) || I_QUAD_LANE_ENABLE);
    assign prot_hit = is_chip(op_r) ? I_ANY_PROTECTED
        : (I_PROTECT_MODE_SELECT ? I_LOCK_HIT : I_BLOCK_PROTECT_HIT);
    assign launch = cs_rise && !wip_r && wel_r && (chip_ok || erase_ok || prog_ok);

    logic [31:0] cnt_r;
    logic [8:0] walk_r;
    logic [PAGE_AW-1:0] pend_idx_r;
    logic pend_r;
    logic [ADDR_W-PAGE_AW-1:0] page_r;
    logic erase_go_r;
    sfep_erase_kind_t erase_kind_r;
    logic [ADDR_W-1:0] erase_base_r;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            eng_r <= EN_IDLE;
            wip_r <= 1'b0;
            wel_r <= 1'b0;
            cnt_r <= CNT_RST;
            walk_r <= 9'h000;
            page_r <= 16'h0000;
            erase_go_r <= 1'b0;
            erase_kind_r <= ERK_64K;
            erase_base_r <= ADDR_RST;
        end else begin
            erase_go_r <= 1'b0;
            case (eng_r)
                EN_IDLE: begin
                    if (cs_rise && !wip_r && write_enable_cmd_ok) begin
                        wel_r <= 1'b1;
                    end
                    if (launch) begin
                        wip_r <= 1'b1;
                        page_r <= addr_r[ADDR_W-1:PAGE_AW];
                        if (prot_hit) begin
                            eng_r <= EN_END;
                        end else if (is_prog(op_r)) begin
                            walk_r <= 9'h000;
                            eng_r <= EN_PROG;
                        end else begin
                            erase_go_r <= 1'b1;
                            eng_r <= EN_WAIT;
                            if (is_chip(op_r)) begin
                                erase_kind_r <= ERK_CHIP;
                                erase_base_r <= ADDR_RST;
                                cnt_r <= 32'(P_ARRAY_ERASE_CYC);
                            end else if (op_r == OP_BLOCK_ERASE_64K) begin
                                erase_kind_r <= ERK_64K;
                                erase_base_r <= {addr_r[ADDR_W-1:BLK64_LOW_BITS], 16'h0000};
                                cnt_r <= 32'(P_BLOCK_ERASE_CYC);
                            end else begin
                                erase_kind_r <= ERK_32K;
                                erase_base_r <= {addr_r[ADDR_W-1:BLK32_LOW_BITS], 15'h0000};
                                cnt_r <= 32'(P_BLOCK_ERASE_CYC);
                            end
                        end
                    end
                end
                EN_PROG: begin
                    walk_r <= 9'(walk_r + 9'h001);
                    if (walk_r == 9'(PAGE_BYTES)) begin
                        cnt_r <= 32'(P_PAGE_WRITE_CYC);
                        eng_r <= EN_WAIT;
                    end
                end
                EN_WAIT: begin
                    // a new frame cannot disturb the cycle, launch is gated by busy
                    if (cnt_r <= 32'h00000001) begin
                        eng_r <= EN_END;
                    end else begin
                        cnt_r <= cnt_r - 32'h00000001;
                    end
                end
                EN_END: begin
                    wip_r <= 1'b0;
                    wel_r <= 1'b0;
                    eng_r <= EN_IDLE;
                end
                default: begin
                    eng_r <= EN_IDLE;
                end
            endcase
        end
    end

    // walk the whole page but strobe only bytes that were received
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pend_r <= 1'b0;
            pend_idx_r <= 8'h00;
        end else begin
            pend_r <= (eng_r == EN_PROG) && (walk_r < 9'(PAGE_BYTES));
            pend_idx_r <= walk_r[PAGE_AW-1:0];
        end
    end

    logic [7:0] rd_data;

    sfep_page_buf #(
        .DW(8),
        .DEPTH(PAGE_BYTES),
        .AW(PAGE_AW)
    ) u_buf (
        .i_clk(I_CLK),
        .i_wr_en(buf_wr),
        .i_wr_addr(idx_r),
        .i_wr_data(sh_nxt),
        .i_rd_addr(walk_r[PAGE_AW-1:0]),
        .o_rd_data(rd_data)
    );

    assign O_WRITE_IN_PROGRESS = wip_r;
    assign O_WRITE_ENABLE_LATCH = wel_r;
    assign O_CHECK_ADDR = addr_r;
    assign O_ERASE_GO = erase_go_r;
    assign O_ERASE_KIND = erase_kind_r;
    assign O_ERASE_BASE = erase_base_r;
    assign O_PROG_WE = pend_r && valid_r[pend_idx_r];
    assign O_PROG_ADDR = {page_r, pend_idx_r};
    assign O_PROG_DATA = rd_data;

    chk_busy_needs_latch: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $rose(wip_r) |-> wel_r) else $error("busy started without write enable latch");
    chk_busy_from_release: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $rose(wip_r) |-> $past(cs_rise)) else $error("busy started without select release");
    chk_end_clears_latch: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $fell(wip_r) |-> !wel_r) else $error("latch still set after cycle end");
    chk_erase_busy_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_ERASE_GO |-> wip_r [*4]) else $error("busy dropped early during erase");
    chk_blk64_align: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_ERASE_GO && O_ERASE_KIND == ERK_64K |-> O_ERASE_BASE[15:0] == 16'h0000
        && O_ERASE_BASE[23:16] == $past(addr_r[23:16])) else $error("64K erase base wrong");
    chk_blk32_align: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_ERASE_GO && O_ERASE_KIND == ERK_32K |-> O_ERASE_BASE[14:0] == 15'h0000
        && O_ERASE_BASE[23:15] == $past(addr_r[23:15])) else $error("32K erase base wrong");
    chk_protect_blocks: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $rose(wip_r) && $past(prot_hit) |-> !O_ERASE_GO ##1 !wip_r && !wel_r)
        else $error("protected target was altered");
    chk_chip_protect: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_ERASE_GO && O_ERASE_KIND == ERK_CHIP |-> $past(!I_ANY_PROTECTED))
        else $error("chip erase ran while protected");
    chk_quad_enable: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $rose(wip_r) && $past(op_r) == OP_QUAD_PAGE_WRITE |-> $past(I_QUAD_LANE_ENABLE))
        else $error("quad write accepted without quad enable");
    chk_busy_ignores: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        wip_r && eng_r == EN_WAIT && cnt_r > 32'h00000002 |=> eng_r == EN_WAIT && !O_ERASE_GO)
        else $error("busy cycle disturbed");
    chk_prog_in_page: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_PROG_WE |-> wip_r && O_PROG_ADDR[23:8] == page_r && $past(eng_r) == EN_PROG)
        else $error("program strobe outside page walk");

    cov_block_erase: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_ERASE_GO && O_ERASE_KIND == ERK_64K);
    cov_chip_erase: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_ERASE_GO && O_ERASE_KIND == ERK_CHIP);
    cov_page_write: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_PROG_WE && op_r == OP_PAGE_WRITE);
    cov_quad_write: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_PROG_WE && op_r == OP_QUAD_PAGE_WRITE);
endmodule
`default_nettype wire

// ===== sfep_pkg.sv
`default_nettype none
package sfep_pkg;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_BLOCK_ERASE_64K = 8'hD8;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_ARRAY_ERASE_A = 8'h60;
    localparam logic [7:0] OP_ARRAY_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h38;
    localparam int ADDR_W = 24;
    localparam int PAGE_BYTES = 256;
    localparam int PAGE_AW = 8;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam int BLK64_LOW_BITS = 16;
    localparam int BLK32_LOW_BITS = 15;
    localparam int CLK_HZ = 20_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int BLOCK_ERASE_TIME_US = 1000;
    localparam int ARRAY_ERASE_TIME_US = 20000;
    localparam int PAGE_WRITE_TIME_US = 1000;
    localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CYC_PER_US;
    localparam int ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * CYC_PER_US;
    localparam int PAGE_WRITE_CYC = PAGE_WRITE_TIME_US * CYC_PER_US;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [31:0] CNT_RST = 32'h00000000;
    typedef enum logic [1:0] {
        ERK_64K = 2'h0,
        ERK_32K = 2'h1,
        ERK_CHIP = 2'h2
    } sfep_erase_kind_t;
endpackage
`default_nettype wire

// ===== sfep_page_buf.sv
`timescale 1ns/100ps
`default_nettype none
module sfep_page_buf #(
    parameter int DW = 8,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DW-1:0] o_rd_data
);
    logic [DW-1:0] mem_r [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem_r[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rd_data <= mem_r[i_rd_addr];
    end
endmodule
`default_nettype wire

// ===== sfep_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the serial link; serial clock idles low between frames
module sfep_host_model (
    input wire logic i_clk,
    output logic o_sclk,
    output logic o_cs_n,
    output logic [3:0] o_sio
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sio = 4'hA;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic start();
        tick(1);
        o_cs_n <= 1'b0;
        tick(4);
    endtask

    // 4 clk per half period gives 400 ns, far below the quad speed ceiling
    task automatic lanes(input logic [3:0] v, input bit quad);
        // upper lanes toggle on single-lane bits so ignoring them is tested
        o_sio <= quad ? v : {~o_sio[3:1], v[0]};
        tick(4);
        o_sclk <= 1'b1;
        tick(4);
        o_sclk <= 1'b0;
    endtask

    // whole bytes unless a scenario asks for a partial one
    task automatic put(input logic [7:0] b, input int nbits, input bit quad);
        if (quad) begin
            lanes(b[7:4], 1'b1);
            lanes(b[3:0], 1'b1);
        end else begin
            for (int i = 0; i < nbits; i++) begin
                lanes({3'h0, b[7-i]}, 1'b0);
            end
        end
    endtask

    // released lanes show the inverse of the last value, never a stale copy
    task automatic stop();
        tick(4);
        o_cs_n <= 1'b1;
        o_sio <= ~o_sio;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sfep_pkg::*;
    localparam int PB = 1000;
    logic I_CLK, I_RST_N, I_SCLK, I_CS_N, I_QUAD_LANE_ENABLE, I_PROTECT_MODE_SELECT;
    logic I_BLOCK_PROTECT_HIT, I_LOCK_HIT, I_ANY_PROTECTED;
    logic [3:0] I_SIO;
    logic O_WRITE_IN_PROGRESS, O_WRITE_ENABLE_LATCH, O_ERASE_GO, O_PROG_WE;
    logic [23:0] O_CHECK_ADDR, O_ERASE_BASE, O_PROG_ADDR, go_base;
    logic [7:0] O_PROG_DATA;
    sfep_erase_kind_t O_ERASE_KIND, go_kind;
    logic [7:0] pmem [logic [23:0]];
    int fail_count = 0, checked = 0, go_cnt = 0, we_cnt = 0, cur = 0, last_len = 0, go0, we0;

    sfep_flash_engine #(.P_BLOCK_ERASE_CYC(PB), .P_ARRAY_ERASE_CYC(300), .P_PAGE_WRITE_CYC(50))
    sfep_flash_engine_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N),
        .I_SIO(I_SIO), .I_QUAD_LANE_ENABLE(I_QUAD_LANE_ENABLE),
        .I_PROTECT_MODE_SELECT(I_PROTECT_MODE_SELECT), .I_BLOCK_PROTECT_HIT(I_BLOCK_PROTECT_HIT),
        .I_LOCK_HIT(I_LOCK_HIT), .I_ANY_PROTECTED(I_ANY_PROTECTED),
        .O_WRITE_IN_PROGRESS(O_WRITE_IN_PROGRESS), .O_WRITE_ENABLE_LATCH(O_WRITE_ENABLE_LATCH),
        .O_CHECK_ADDR(O_CHECK_ADDR), .O_ERASE_GO(O_ERASE_GO), .O_ERASE_KIND(O_ERASE_KIND),
        .O_ERASE_BASE(O_ERASE_BASE), .O_PROG_WE(O_PROG_WE), .O_PROG_ADDR(O_PROG_ADDR),
        .O_PROG_DATA(O_PROG_DATA));
    sfep_host_model sfep_host_model_i (.i_clk(I_CLK), .o_sclk(I_SCLK), .o_cs_n(I_CS_N), .o_sio(I_SIO));

    initial begin
        I_CLK = 1'b0;
        forever #25 I_CLK = ~I_CLK;
    end

    // records what reaches the array, plus the length of the last busy spell
    always @(posedge I_CLK) begin
        if (O_ERASE_GO === 1'b1) begin
            go_cnt++;
            go_kind = O_ERASE_KIND;
            go_base = O_ERASE_BASE;
        end
        if (O_PROG_WE === 1'b1) begin
            we_cnt++;
            pmem[O_PROG_ADDR] = O_PROG_DATA;
        end
        if (O_WRITE_IN_PROGRESS === 1'b1) begin
            cur++;
        end else if (cur != 0) begin
            last_len = cur;
            cur = 0;
        end
    end

    function automatic logic [7:0] dat(input int i);
        return 8'(i) ^ ((i >= 256) ? 8'hFF : 8'h3C);
    endfunction

    task automatic wrap_up();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_val(input string name, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic frame(input logic [7:0] op, input int nadr, input logic [23:0] a,
                         input int ndata, input bit quad, input int tail);
        go0 = go_cnt;
        we0 = we_cnt;
        last_len = 0;
        sfep_host_model_i.start();
        sfep_host_model_i.put(op, 8, 1'b0);
        for (int i = 0; i < nadr; i++) begin
            sfep_host_model_i.put(a[23-8*i -: 8], 8, quad);
        end
        for (int i = 0; i < ndata; i++) begin
            sfep_host_model_i.put(dat(i), 8, quad);
        end
        if (tail > 0) begin
            sfep_host_model_i.put(8'h5A, tail, 1'b0);
        end
        sfep_host_model_i.stop();
    endtask

    task automatic write_enable_cmd();
        frame(OP_WRITE_ENABLE_CMD, 0, 24'h0, 0, 1'b0, 0);
        cmp_val("latch_set", 24'h1, {23'h0, O_WRITE_ENABLE_LATCH});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (O_WRITE_IN_PROGRESS !== 1'b0) begin
            @(posedge I_CLK);
            n++;
            if (n > 30000) begin
                fail_count++;
                $display("MISMATCH wait_idle expected 0 seen 1");
                wrap_up();
            end
        end
        repeat (2) @(posedge I_CLK);
    endtask

    // mode 0 refused with latch kept, 1 carried out, 2 protected, 3 refused with latch clear
    task automatic outcome(input int mode, input int go_d, input int we_d);
        wait_idle();
        cmp_val("erase_go_count", 24'(go_d), 24'(go_cnt - go0));
        cmp_val("prog_we_count", 24'(we_d), 24'(we_cnt - we0));
        cmp_val("latch_after", {23'h0, mode == 0}, {23'h0, O_WRITE_ENABLE_LATCH});
        if (mode == 2) begin
            cmp_val("busy_len", 24'h1, 24'(last_len));
        end else begin
            cmp_val("busy_seen", {23'h0, mode == 1}, {23'h0, last_len > 40});
        end
    endtask

    initial begin
        I_RST_N = 1'b0;
        {I_QUAD_LANE_ENABLE, I_PROTECT_MODE_SELECT, I_BLOCK_PROTECT_HIT, I_LOCK_HIT, I_ANY_PROTECTED} = 5'h00;
        repeat (16) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        cmp_val("reset_busy", 24'h0, {23'h0, O_WRITE_IN_PROGRESS});
        cmp_val("reset_latch", 24'h0, {23'h0, O_WRITE_ENABLE_LATCH});
        frame(OP_BLOCK_ERASE_64K, 3, 24'h123456, 0, 1'b0, 0);
        outcome(3, 0, 0);
        write_enable_cmd();
        frame(OP_BLOCK_ERASE_64K, 3, 24'h123456, 0, 1'b0, 0);
        cmp_val("busy_after_release", 24'h1, {23'h0, O_WRITE_IN_PROGRESS});
        outcome(1, 1, 0);
        cmp_val("kind_64k", 24'(ERK_64K), 24'(go_kind));
        cmp_val("base_64k", 24'h120000, go_base);
        cmp_val("check_addr", 24'h123456, O_CHECK_ADDR);
        write_enable_cmd();
        frame(OP_HALF_BLOCK_ERASE, 3, 24'h12ABCD, 0, 1'b0, 0);
        outcome(1, 1, 0);
        cmp_val("kind_32k", 24'(ERK_32K), 24'(go_kind));
        cmp_val("base_32k", 24'h128000, go_base);
        for (int k = 0; k < 2; k++) begin
            write_enable_cmd();
            frame(k == 0 ? OP_ARRAY_ERASE_A : OP_ARRAY_ERASE_B, 0, 24'h0, 0, 1'b0, 0);
            outcome(1, 1, 0);
            cmp_val("kind_chip", 24'(ERK_CHIP), 24'(go_kind));
            cmp_val("base_chip", 24'h0, go_base);
        end
        write_enable_cmd();
        frame(OP_BLOCK_ERASE_64K, 3, 24'h340000, 0, 1'b0, 3);
        outcome(0, 0, 0);
        frame(OP_BLOCK_ERASE_64K, 3, 24'h340000, 0, 1'b0, 8);
        outcome(0, 0, 0);
        frame(OP_BLOCK_ERASE_64K, 2, 24'h340000, 0, 1'b0, 0);
        outcome(0, 0, 0);
        frame(OP_PAGE_WRITE, 3, 24'h0012FE, 1, 1'b0, 4);
        outcome(0, 0, 0);
        frame(OP_PAGE_WRITE, 3, 24'h0012FE, 0, 1'b0, 0);
        outcome(0, 0, 0);
        frame(OP_PAGE_WRITE, 3, 24'h0012FE, 3, 1'b0, 0);
        outcome(1, 0, 3);
        cmp_val("wrap_fe", {16'h0, dat(0)}, {16'h0, pmem[24'h0012FE]});
        cmp_val("wrap_ff", {16'h0, dat(1)}, {16'h0, pmem[24'h0012FF]});
        cmp_val("wrap_00", {16'h0, dat(2)}, {16'h0, pmem[24'h001200]});
        write_enable_cmd();
        frame(OP_PAGE_WRITE, 3, 24'h003400, 258, 1'b0, 0);
        outcome(1, 0, 256);
        cmp_val("last_idx0", {16'h0, dat(256)}, {16'h0, pmem[24'h003400]});
        cmp_val("last_idx1", {16'h0, dat(257)}, {16'h0, pmem[24'h003401]});
        cmp_val("last_idx2", {16'h0, dat(2)}, {16'h0, pmem[24'h003402]});
        write_enable_cmd();
        frame(OP_QUAD_PAGE_WRITE, 3, 24'h005010, 2, 1'b1, 0);
        outcome(0, 0, 0);
        I_QUAD_LANE_ENABLE <= 1'b1;
        frame(OP_QUAD_PAGE_WRITE, 3, 24'h005010, 2, 1'b1, 0);
        outcome(1, 0, 2);
        cmp_val("quad_b0", {16'h0, dat(0)}, {16'h0, pmem[24'h005010]});
        cmp_val("quad_b1", {16'h0, dat(1)}, {16'h0, pmem[24'h005011]});
        write_enable_cmd();
        I_BLOCK_PROTECT_HIT <= 1'b1;
        frame(OP_BLOCK_ERASE_64K, 3, 24'h200000, 0, 1'b0, 0);
        outcome(2, 0, 0);
        write_enable_cmd();
        I_PROTECT_MODE_SELECT <= 1'b1;
        frame(OP_BLOCK_ERASE_64K, 3, 24'h200000, 0, 1'b0, 0);
        outcome(1, 1, 0);
        write_enable_cmd();
        I_LOCK_HIT <= 1'b1;
        frame(OP_QUAD_PAGE_WRITE, 3, 24'h006000, 1, 1'b1, 0);
        outcome(2, 0, 0);
        write_enable_cmd();
        I_ANY_PROTECTED <= 1'b1;
        frame(OP_ARRAY_ERASE_B, 0, 24'h0, 0, 1'b0, 0);
        outcome(2, 0, 0);
        {I_PROTECT_MODE_SELECT, I_BLOCK_PROTECT_HIT, I_LOCK_HIT, I_ANY_PROTECTED} <= 4'h0;
        write_enable_cmd();
        frame(OP_BLOCK_ERASE_64K, 3, 24'h210000, 0, 1'b0, 0);
        go0 = go_cnt;
        sfep_host_model_i.start();
        sfep_host_model_i.put(OP_BLOCK_ERASE_64K, 8, 1'b0);
        sfep_host_model_i.put(8'h30, 8, 1'b0);
        sfep_host_model_i.put(8'h00, 8, 1'b0);
        sfep_host_model_i.put(8'h00, 8, 1'b0);
        sfep_host_model_i.stop();
        frame(OP_WRITE_ENABLE_CMD, 0, 24'h0, 0, 1'b0, 0);
        wait_idle();
        cmp_val("busy_go_count", 24'h0, 24'(go_cnt - go0));
        cmp_val("busy_base", 24'h210000, go_base);
        cmp_val("busy_latch", 24'h0, {23'h0, O_WRITE_ENABLE_LATCH});
        wrap_up();
    end
endmodule
`default_nettype wire
